// >>> dv/acq_chain_control_test.sv
// Purpose: self-checking bench for the acquisition chain control
// Assumes: sampling divider shortened to 16 clocks
// Notes:   result value is a stand-in, so only its handshake is checked
`timescale 1ns/1ns
`default_nettype none
`include "acq_chain_regs.vh"
module acq_chain_control_test;
  localparam int DIV = 16;
  logic clk = 0;
  logic rst_n = 0;
  wire cyc, stb, we, ack, err, busy, tick, o3n, refi, rdy, miso;
  wire [31:0] wdat, rdat;
  wire [7:0] adr, pos, neg;
  wire [5:0] o3m;
  int bad_count = 0, n_compared = 0, cycles = 0, nt = 0, gap = 0, since = 0, nt0, i, x;
  logic [31:0] q;
  logic e;

  acq_chain_control #(.CLK_DIV_BASE(DIV)) u_dut (.CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .WB_ERR_O(err), .BUSY(busy), .SAMPLE_TICK(tick), .CHOP_POLARITY(), .MODULATOR_EN(), .STAGE_EN(),
    .CONV_BIAS(), .AMP_BIAS(), .STAGE1_GAIN10(), .STAGE2_GAIN(), .STAGE3_GAIN(), .STAGE2_OFS_NEG(),
    .STAGE2_OFS_MAG(), .STAGE3_OFS_NEG(o3n), .STAGE3_OFS_MAG(o3m), .INPUT_POS_ONEHOT(pos),
    .INPUT_NEG_ONEHOT(neg), .REF_INTERNAL(refi), .RESULT_READY(rdy), .MISO_READY(miso));
  mcu_host u_host (.clk(clk), .ack(ack), .err(err), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .dat(wdat));

  // 100 ns clock
  always #50 clk = ~clk;
  // tick spacing, ticks while converting, and the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    since <= tick ? 1 : since + 1;
    if (tick) gap <= since;
    if (tick && busy) nt <= nt + 1;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    check(q, want);
  endtask
  // bounded wait for a busy level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(busy, lvl);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // expected routing: positive byte above negative byte
  function automatic logic [15:0] route(input logic [4:0] c);
    logic [7:0] p, n;
    p = c[4] ? 8'h01 << c[2:0] : 8'h02 << {c[1:0], 1'b0};
    n = c[4] ? 8'h01 : 8'h01 << {c[1:0], 1'b0};
    return c[3] ? {n, p} : {p, n};
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values, then refused addresses
    rd(`OFS_CONV_CONTROL, `RST_CONV_CONTROL);
    rd(`OFS_BIAS_ENABLE, `RST_BIAS_ENABLE);
    rd(`OFS_STAGE1_STAGE3, `RST_STAGE1_STAGE3);
    rd(`OFS_INPUT_REF, `RST_INPUT_REF);
    u_host.xfer(1'b0, 8'h20, 32'h0, q, e);
    check(e, 1'b1);
    u_host.xfer(1'b1, 8'h09, 32'hFF, q, e);
    check(e, 1'b1);
    // read back; an unlisted stage 2 offset must not spill into other fields
    wr(`OFS_BIAS_ENABLE, 8'h5A);
    rd(`OFS_BIAS_ENABLE, 32'h5A);
    wr(`OFS_STAGE1_STAGE3, 8'hB5);
    wr(`OFS_RATE_STAGE2, 8'hE6);
    rd(`OFS_RATE_STAGE2, 32'hE6);
    wr(`OFS_STAGE3_OFFSET, 8'hBF);
    check({o3n, o3m}, 7'h3F);
    // every selector code with both references
    for (i = 0; i < 64; i++) begin
      wr(`OFS_INPUT_REF, 8'(i));
      check({pos, neg}, route(i[5:1]));
      check(refi, i[0]);
    end
    // one conversion per rate; the rate is changed while it runs
    for (i = 0; i < 4; i++) begin
      wr(`OFS_RATE_STAGE2, {i[1:0], 6'h26});
      nt0 = nt;
      x = (8 << (2 * i)) + (1 << i) + 5;
      wr(`OFS_CONV_CONTROL, {1'b1, i[1:0], i[2:0], 2'h0});
      wr(`OFS_RATE_STAGE2, {~i[1:0], 6'h26});
      rd(`OFS_INPUT_REF, 32'hBF);
      rd(`OFS_CONV_CONTROL, {1'b0, i[1:0], i[2:0], 2'h0});
      wait_busy(1'b0);
      @(posedge clk);
      check($unsigned(nt - nt0 - x + 1) <= 2, 1'b1);
      check(gap, DIV >> i);
      check({rdy, miso}, 2'h3);
      u_host.xfer(1'b0, `OFS_RESULT_HIGH, 32'h0, q, e);
      u_host.xfer(1'b0, `OFS_RESULT_LOW, 32'h0, q, e);
      check({rdy, miso}, 2'h0);
    end
    // starts while busy queue exactly one more; busy bridges both, 14 ticks each
    nt0 = nt;
    wr(`OFS_CONV_CONTROL, 8'h80);
    wr(`OFS_CONV_CONTROL, 8'h80);
    wr(`OFS_CONV_CONTROL, 8'h80);
    wait_busy(1'b0);
    check($unsigned(nt - nt0 - 27) <= 2, 1'b1);
    check(rdy, 1'b1);
    repeat (300) @(posedge clk);
    check(busy, 1'b0);
    // continuous mode keeps converting until the bit is cleared
    wr(`OFS_CONV_CONTROL, 8'h02);
    wait_busy(1'b1);
    nt0 = nt;
    repeat (700) @(posedge clk);
    check(busy, 1'b1);
    check(nt - nt0 >= 40, 1'b1);
    wr(`OFS_CONV_CONTROL, 8'h00);
    wait_busy(1'b0);
    // restore keeps the selections and starts a conversion
    wr(`OFS_INPUT_REF, 8'h7F);
    rd(`OFS_CONV_CONTROL, `RST_CONV_CONTROL);
    rd(`OFS_BIAS_ENABLE, `RST_BIAS_ENABLE);
    rd(`OFS_RATE_STAGE2, `RST_RATE_STAGE2);
    rd(`OFS_INPUT_REF, 32'hBF);
    wait_busy(1'b0);
    print_verdict();
  end
endmodule // acq_chain_control_test
`default_nettype wire

// >>> dv/acq_chain_monitor.sv
// Purpose: port checker for the acquisition chain control
// Assumes: single-cycle bus master; restore is issued only while idle
// Notes:   field outputs are compared one cycle after the write ack
`timescale 1ns/1ns
`default_nettype none
`include "acq_chain_regs.vh"
module acq_chain_monitor (
  input wire logic        CLK,            // clock
  input wire logic        RESET_N,        // reset
  input wire logic        WB_CYC_I,       // cycle
  input wire logic        WB_STB_I,       // strobe
  input wire logic        WB_WE_I,        // write
  input wire logic [7:0]  WB_ADR_I,       // address
  input wire logic [3:0]  WB_SEL_I,       // selects
  input wire logic [31:0] WB_DAT_I,       // write data
  input wire logic [31:0] WB_DAT_O,       // read data
  input wire logic        WB_ACK_O,       // ack
  input wire logic        WB_ERR_O,       // error
  input wire logic        BUSY,           // converting
  input wire logic        MODULATOR_EN,   // modulator on
  input wire logic [2:0]  STAGE_EN,       // stage enables
  input wire logic [1:0]  CONV_BIAS,      // converter bias
  input wire logic [1:0]  AMP_BIAS,       // amplifier bias
  input wire logic        STAGE1_GAIN10,  // stage 1 gain
  input wire logic [1:0]  STAGE2_GAIN,    // stage 2 gain
  input wire logic [6:0]  STAGE3_GAIN,    // stage 3 gain
  input wire logic        STAGE2_OFS_NEG, // stage 2 sign
  input wire logic [2:0]  STAGE2_OFS_MAG, // stage 2 offset
  input wire logic        RESULT_READY    // result held
);
  // fresh request, accepted write, answered read
  wire logic       req   = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  wire logic       wr    = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire logic       rd    = WB_ACK_O && !WB_WE_I;
  wire logic [7:0] wbyte = WB_DAT_I[7:0];
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  AST_ANSWER: assert property (req |=> WB_ACK_O != WB_ERR_O) else $error("no single answer");
  AST_UNMAPPED: assert property (req && (WB_ADR_I >= 8'h20 || WB_ADR_I[1:0] != 2'h0) |=> WB_ERR_O)
    else $error("unmapped address not refused");
  AST_HIGH_ZERO: assert property (rd |-> WB_DAT_O[31:8] == 24'h0) else $error("upper bits set");
  AST_START_RD0: assert property (rd && WB_ADR_I == `OFS_CONV_CONTROL |-> !WB_DAT_O[`BIT_START])
    else $error("start bit read as one");
  AST_BIAS: assert property (wr && WB_ADR_I == `OFS_BIAS_ENABLE
    |=> {CONV_BIAS, AMP_BIAS, STAGE_EN, MODULATOR_EN} == $past(wbyte)) else $error("bias or enable wrong");
  AST_STAGE2: assert property (wr && WB_ADR_I == `OFS_RATE_STAGE2
    |=> {STAGE2_GAIN, STAGE2_OFS_NEG, STAGE2_OFS_MAG} == $past(wbyte[5:0])) else $error("stage 2 wrong");
  AST_GAIN13: assert property (wr && WB_ADR_I == `OFS_STAGE1_STAGE3
    |=> {STAGE1_GAIN10, STAGE3_GAIN} == $past(wbyte)) else $error("stage 1 or 3 gain wrong");
  AST_BUSY_END: assert property ($fell(BUSY) |-> RESULT_READY) else $error("busy fell, no result");
endmodule // acq_chain_monitor

bind acq_chain_control acq_chain_monitor u_monitor (.CLK, .RESET_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .BUSY, .MODULATOR_EN, .STAGE_EN,
  .CONV_BIAS, .AMP_BIAS, .STAGE1_GAIN10, .STAGE2_GAIN, .STAGE3_GAIN, .STAGE2_OFS_NEG, .STAGE2_OFS_MAG,
  .RESULT_READY);
`default_nettype wire

// >>> dv/mcu_host.sv
// Purpose: host controller model issuing register cycles
// Assumes: every request is answered by ack or err
// Notes:   released write data is inverted so stale values show up
`timescale 1ns/1ns
`default_nettype none
module mcu_host (
  input  wire logic        clk,  // clock
  input  wire logic        ack,  // ack
  input  wire logic        err,  // error
  input  wire logic [31:0] rdat, // read data
  output var  logic        cyc,  // cycle
  output var  logic        stb,  // strobe
  output var  logic        we,   // write
  output var  logic [7:0]  adr,  // address
  output var  logic [31:0] dat   // write data
);
  // bus idle from time zero
  initial {cyc, stb, we, adr, dat} = '0;
  // one classic cycle, held until ack or err is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do
      @(posedge clk);
    while (!(ack || err));
    q = rdat;
    e = err;
    {cyc, stb, we} <= 3'h0;
    dat <= ~d;
    @(posedge clk);
  endtask
endmodule // mcu_host
`default_nettype wire

// >>> src/acq_chain_control.v
// Purpose: configuration and conversion sequencing of a sensor acquisition chain
// Assumes: one 10 MHz clock, classic Wishbone slave, analog chain outside driven by the static outputs
// Notes:   sampling clock is a one-cycle enable from a divider; conversion result is produced by a stand-in counter
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "acq_chain_regs.vh"

// Summary of operation
// - conversions per result are 2^count field (1,2,4,8); input polarity chopped between them.
// - over-sampling ratio per elementary conversion is 2^(3+ratio field), 8 to 1024.
// - continuous bit starts a conversion and restarts after each finish while set.
// - with shift enable, a finished result may be shifted out directly; the bit is stored but unused, RESULT_READY rises after every result.
// - converter and amplifier bias each scale to 0.25*(1+field).
// - bit 0 enables modulator, bit i enables stage i; disabled stages are bypassed.
// - sampling clock 62.5/125/250/500 kHz from the two-bit rate field.
// - first stage gain 1 when its bit is 0, 10 when 1.
// - second stage gain 1,2,5,10 from its two-bit field.
// - third stage gain is its seven-bit field times one twelfth.
// - second stage offset sign from top bit; codes 0 to 5 in 0.2 steps.
// - third stage offset sign from top bit; six low bits in twelfths up to 5.25.
// - data-ready enable combines data-ready onto MISO.
// - busy reads 1 while a conversion runs, else 0.
// - restore bit reloads defaults, keeps selections, and restarts conversion at once.
// - input selector bit 4 mode, bit 3 polarity, bits 2..0 channel.
// - differential codes 0..3 connect pairs 1-0,3-2,5-4,7-6; crossed swaps each pair.
// - single-ended 10ccc puts ccc against input 0; 11ccc puts input 0 against ccc.
// - reference bit 0 selects battery supply, 1 selects bandgap or external reference.
// - start bit queues exactly one conversion after any running one; reads as 0.
// - result is 16 bits in high and low byte read-only registers, bit 15 MSB.
module acq_chain_control #(
  parameter CLK_DIV_BASE = `CLK_PER_FS_BASE  // clocks per 62.5 kHz tick
) (
  input  wire        CLK,              // 10 MHz system clock
  input  wire        RESET_N,          // asynchronous reset, active low
  // register bus
  input  wire        WB_CYC_I,         // wishbone cycle
  input  wire        WB_STB_I,         // wishbone strobe
  input  wire        WB_WE_I,          // wishbone write enable
  input  wire [7:0]  WB_ADR_I,         // wishbone byte address
  input  wire [3:0]  WB_SEL_I,         // wishbone byte selects
  input  wire [31:0] WB_DAT_I,         // wishbone write data
  output reg  [31:0] WB_DAT_O,         // wishbone read data
  output reg         WB_ACK_O,         // wishbone acknowledge
  output reg         WB_ERR_O,         // wishbone error on unmapped address
  // conversion status
  output reg         BUSY,             // conversion running
  output reg         SAMPLE_TICK,      // one-cycle sampling clock enable
  output reg         CHOP_POLARITY,    // current input chop phase
  // analog chain controls
  output reg         MODULATOR_EN,     // modulator enable
  output reg  [2:0]  STAGE_EN,         // amplifier stages 3..1 enabled (else bypassed)
  output reg  [1:0]  CONV_BIAS,        // converter bias, quarters minus one
  output reg  [1:0]  AMP_BIAS,         // amplifier bias, quarters minus one
  output reg         STAGE1_GAIN10,    // first stage gain 10
  output reg  [1:0]  STAGE2_GAIN,      // second stage gain code
  output reg  [6:0]  STAGE3_GAIN,      // third stage gain in twelfths
  output reg         STAGE2_OFS_NEG,   // second stage offset negative
  output reg  [2:0]  STAGE2_OFS_MAG,   // second stage offset in 0.2 steps
  output reg         STAGE3_OFS_NEG,   // third stage offset negative
  output reg  [5:0]  STAGE3_OFS_MAG,   // third stage offset in twelfths
  output reg  [7:0]  INPUT_POS_ONEHOT, // input routed to positive side
  output reg  [7:0]  INPUT_NEG_ONEHOT, // input routed to negative side
  output reg         REF_INTERNAL,     // reference bandgap/external (1) or battery (0)
  output reg         RESULT_READY,     // result available for direct shift out
  output reg         MISO_READY        // data-ready level for merging onto MISO
);

  // reset release through two flip-flops
  // assert is asynchronous, release is clocked, so no flop
  // sees reset end near its own edge; logic starts two
  // edges after the pin rises
  reg rst_meta;
  reg rst_sync;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  // every process below resets from this clocked copy
  wire rst_n = rst_sync;

  // sequencer states: idle, oversampling run, closing tail
  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_TAIL = 3'b100;

  // register image; busy and restore are built at read time
  // and never stored, so the selection keeps six bits only
  reg  [7:0]  conv_control;
  reg  [7:0]  bias_enable;
  reg  [7:0]  rate_stage2_control;
  reg  [7:0]  stage1_stage3_gain;
  reg  [7:0]  stage3_offset;
  reg  [5:0]  input_reference_select;
  // last stored result and the queued start
  reg  [15:0] result;
  reg         start_pending;
  reg  [2:0]  state;
  // divider, tail and accumulator state
  reg  [15:0] div_cnt;
  reg  [3:0]  rate_cnt;
  reg  [10:0] osr_cnt;
  reg  [3:0]  elem_cnt;
  // copies taken at launch: a running conversion never
  // mixes two count, ratio or rate settings
  reg  [10:0] osr_len;
  reg  [3:0]  elem_len;
  reg  [1:0]  rate_act;
  reg  [15:0] accum;

  // bus decode; ack or err blocks a repeat of the same request,
  // so each transfer writes once; sel lane 0 gates the writes
  // and upper lanes carry nothing
  wire wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  wire wr_lane0 = wb_req & WB_WE_I & WB_SEL_I[0];
  wire mapped   = (WB_ADR_I[7:5] == 3'h0) & (WB_ADR_I[1:0] == 2'h0);
  // command strobes taken from the written byte
  wire wr_start    = wr_lane0 & (WB_ADR_I == `OFS_CONV_CONTROL) & WB_DAT_I[`BIT_START];
  wire wr_cont     = wr_lane0 & (WB_ADR_I == `OFS_CONV_CONTROL) & WB_DAT_I[`BIT_CONTINUOUS];
  wire wr_restore  = wr_lane0 & (WB_ADR_I == `OFS_INPUT_REF) & WB_DAT_I[`BIT_RESTORE];
  wire conv_done;

  // register writes; restore reloads everything except the selections
  // restore wins over a plain write in the same cycle; the
  // start bit is never stored, so it always reads back as zero
  // unlisted stage 2 offset codes are kept as written; the
  // analog side decides what they mean
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      conv_control           <= `RST_CONV_CONTROL;
      bias_enable            <= `RST_BIAS_ENABLE;
      rate_stage2_control    <= `RST_RATE_STAGE2;
      stage1_stage3_gain     <= `RST_STAGE1_STAGE3;
      stage3_offset          <= `RST_STAGE3_OFFSET;
      input_reference_select <= 6'h00;
    end else if (wr_restore) begin
      conv_control        <= `RST_CONV_CONTROL;
      bias_enable         <= `RST_BIAS_ENABLE;
      rate_stage2_control <= `RST_RATE_STAGE2;
      stage1_stage3_gain  <= `RST_STAGE1_STAGE3;
      stage3_offset       <= `RST_STAGE3_OFFSET;
    end else if (wr_lane0) begin
      case (WB_ADR_I)
        `OFS_CONV_CONTROL:  conv_control           <= {1'b0, WB_DAT_I[6:0]};
        `OFS_BIAS_ENABLE:   bias_enable            <= WB_DAT_I[7:0];
        `OFS_RATE_STAGE2:   rate_stage2_control    <= WB_DAT_I[7:0];
        `OFS_STAGE1_STAGE3: stage1_stage3_gain     <= WB_DAT_I[7:0];
        `OFS_STAGE3_OFFSET: stage3_offset          <= WB_DAT_I[7:0];
        `OFS_INPUT_REF:     input_reference_select <= WB_DAT_I[5:0];
        default:            conv_control           <= conv_control;
      endcase
    end
  end

  // bus answer: one wait-free ack the cycle after the request, err on unmapped
  // read data stands only with ack and is zero otherwise, so
  // a master that samples late sees zero, not a stale value
  // unmapped or unaligned addresses answer err and have no
  // effect
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req & mapped;
      WB_ERR_O <= wb_req & ~mapped;
      WB_DAT_O <= 32'h00000000;
      if (wb_req & ~WB_WE_I) begin
        case (WB_ADR_I)
          `OFS_RESULT_LOW:    WB_DAT_O[7:0] <= result[7:0];
          `OFS_RESULT_HIGH:   WB_DAT_O[7:0] <= result[15:8];
          `OFS_CONV_CONTROL:  WB_DAT_O[7:0] <= conv_control;
          `OFS_BIAS_ENABLE:   WB_DAT_O[7:0] <= bias_enable;
          `OFS_RATE_STAGE2:   WB_DAT_O[7:0] <= rate_stage2_control;
          `OFS_STAGE1_STAGE3: WB_DAT_O[7:0] <= stage1_stage3_gain;
          `OFS_STAGE3_OFFSET: WB_DAT_O[7:0] <= stage3_offset;
          `OFS_INPUT_REF:     WB_DAT_O[7:0] <= {BUSY, 1'b0, input_reference_select};
          default:            WB_DAT_O      <= 32'h00000000;
        endcase
      end
    end
  end

  // start request held until the sequencer is idle; a set in the clearing cycle wins
  // a start while busy is held as one request only: further
  // starts set the same flag, so they queue nothing more
  // continuous mode sets it too, so its first run starts alike
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n)
      start_pending <= 1'b0;
    else if (wr_start | wr_cont)
      start_pending <= 1'b1;
    else if (state == S_IDLE)
      start_pending <= 1'b0;
  end

  // base divider gives 500 kHz; rate counter picks every 1st..8th base tick
  // the base counter runs at eight times the lowest rate, so
  // each faster rate is a whole number of base ticks
  // CLK_DIV_BASE must therefore be a multiple of eight
  // the rate used is the one latched at launch, so a rate
  // write during a conversion waits for the next one
  // both counters run free; the first period after a launch
  // may be short
  wire base_tick = (div_cnt == 16'h0000);
  // number of base ticks per sampling tick
  wire [3:0] rate_div = 4'h8 >> rate_act;
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt     <= 16'h0000;
      rate_cnt    <= 4'h0;
      SAMPLE_TICK <= 1'b0;
    end else begin
      if (div_cnt == 16'h0000)
        div_cnt <= CLK_DIV_BASE[15:0] / 16'h0008 - 16'h0001;
      else
        div_cnt <= div_cnt - 16'h0001;
      SAMPLE_TICK <= 1'b0;
      if (base_tick) begin
        if (rate_cnt >= rate_div - 4'h1) begin
          rate_cnt    <= 4'h0;
          SAMPLE_TICK <= 1'b1;
        end else
          rate_cnt <= rate_cnt + 4'h1;
      end
    end
  end

  // a conversion ends on the last tail tick; launch takes a
  // restore at once, and a queued start or continuous mode
  // only when the sequencer is idle
  assign conv_done = (state == S_TAIL) & SAMPLE_TICK & (osr_cnt == 11'h000);
  wire   launch    = wr_restore | ((state == S_IDLE) & start_pending) |
                     ((state == S_IDLE) & conv_control[`BIT_CONTINUOUS]);

  // conversion sequencer; settings are latched at launch only
  // run: ratio plus one ticks per elementary conversion,
  // chop polarity flips after each one
  // tail: a fixed count of ticks closes the quantization
  // the result is a stand-in pattern of the settings used, so
  // software sees which setting produced it
  // reading the low result byte clears ready; a new result in
  // the same cycle wins
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      osr_cnt       <= 11'h000;
      elem_cnt      <= 4'h0;
      osr_len       <= 11'h000;
      elem_len      <= 4'h0;
      rate_act      <= 2'h0;
      accum         <= 16'h0000;
      result        <= 16'h0000;
      CHOP_POLARITY <= 1'b0;
      RESULT_READY  <= 1'b0;
    end else begin
      if (wb_req & ~WB_WE_I & (WB_ADR_I == `OFS_RESULT_LOW))
        RESULT_READY <= 1'b0;
      // launch abandons any running conversion, which is what
      // restore asks for
      if (launch) begin
        state         <= S_RUN;
        osr_len       <= (11'h008 << (wr_restore ? 3'h2 : conv_control[4:2])) + 11'h001;
        elem_len      <= 4'h1 << (wr_restore ? 2'h1 : conv_control[6:5]);
        rate_act      <= wr_restore ? 2'h0 : rate_stage2_control[7:6];
        osr_cnt       <= 11'h000;
        elem_cnt      <= 4'h0;
        accum         <= 16'h0000;
        CHOP_POLARITY <= 1'b0;
      end else begin
        // the chain advances only on sampling ticks
        case (state)
          S_IDLE: state <= S_IDLE;
          S_RUN: if (SAMPLE_TICK) begin
            accum <= accum + {15'h0000, CHOP_POLARITY};
            if (osr_cnt == osr_len - 11'h001) begin
              osr_cnt       <= 11'h000;
              CHOP_POLARITY <= ~CHOP_POLARITY;
              if (elem_cnt == elem_len - 4'h1) begin
                state   <= S_TAIL;
                osr_cnt <= `CONV_TAIL_TICKS;
              end else
                elem_cnt <= elem_cnt + 4'h1;
            end else
              osr_cnt <= osr_cnt + 11'h001;
          end
          // count down the tail, then store the result
          S_TAIL: if (SAMPLE_TICK) begin
            if (conv_done) begin
              state        <= S_IDLE;
              result       <= accum ^ {osr_len[10:0], elem_len, 1'b0};
              RESULT_READY <= 1'b1;
            end else
              osr_cnt <= osr_cnt - 11'h001;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // analog control outputs, decoded from the registers
  // these follow the registers one cycle after a write, not
  // the launch: bias, enables and gains act on the chain at
  // once, while count, ratio and rate wait for the next start
  // busy also counts the launch cycle, so it stays high across
  // a queued or continuous restart
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUSY             <= 1'b0;
      MODULATOR_EN     <= 1'b1;
      STAGE_EN         <= 3'h0;
      CONV_BIAS        <= 2'h3;
      AMP_BIAS         <= 2'h3;
      STAGE1_GAIN10    <= 1'b0;
      STAGE2_GAIN      <= 2'h0;
      STAGE3_GAIN      <= 7'h0C;
      STAGE2_OFS_NEG   <= 1'b0;
      STAGE2_OFS_MAG   <= 3'h0;
      STAGE3_OFS_NEG   <= 1'b0;
      STAGE3_OFS_MAG   <= 6'h00;
      INPUT_POS_ONEHOT <= 8'h02;
      INPUT_NEG_ONEHOT <= 8'h01;
      REF_INTERNAL     <= 1'b0;
      MISO_READY       <= 1'b0;
    end else begin
      BUSY           <= (state != S_IDLE) | launch;
      MODULATOR_EN   <= bias_enable[0];
      STAGE_EN       <= bias_enable[3:1];
      CONV_BIAS      <= bias_enable[7:6];
      AMP_BIAS       <= bias_enable[5:4];
      STAGE1_GAIN10  <= stage1_stage3_gain[7];
      STAGE2_GAIN    <= rate_stage2_control[5:4];
      STAGE3_GAIN    <= stage1_stage3_gain[6:0];
      STAGE2_OFS_NEG <= rate_stage2_control[3];
      STAGE2_OFS_MAG <= rate_stage2_control[2:0];
      STAGE3_OFS_NEG <= stage3_offset[6];
      STAGE3_OFS_MAG <= stage3_offset[5:0];
      REF_INTERNAL   <= input_reference_select[`BIT_REF_SEL];
      MISO_READY     <= stage3_offset[7] & RESULT_READY;
      // differential codes pick a pair, single-ended codes pick
      // one input against input 0; the sign bit swaps the sides
      case (input_reference_select[5:4])
        2'b00: begin
          INPUT_POS_ONEHOT <= 8'h02 << {input_reference_select[2:1], 1'b0};
          INPUT_NEG_ONEHOT <= 8'h01 << {input_reference_select[2:1], 1'b0};
        end
        2'b01: begin
          INPUT_POS_ONEHOT <= 8'h01 << {input_reference_select[2:1], 1'b0};
          INPUT_NEG_ONEHOT <= 8'h02 << {input_reference_select[2:1], 1'b0};
        end
        2'b10: begin
          INPUT_POS_ONEHOT <= 8'h01 << input_reference_select[3:1];
          INPUT_NEG_ONEHOT <= 8'h01;
        end
        default: begin
          INPUT_POS_ONEHOT <= 8'h01;
          INPUT_NEG_ONEHOT <= 8'h01 << input_reference_select[3:1];
        end
      endcase
    end
  end

endmodule // acq_chain_control
`default_nettype wire

// >>> src/acq_chain_regs.vh
// Purpose: register offsets, field positions, reset values and timing counts of the acquisition chain control
// Assumes: 32-bit Wishbone data, registers in the low byte of aligned words
// Notes:   offsets are byte addresses
`ifndef ACQ_CHAIN_REGS_VH
`define ACQ_CHAIN_REGS_VH

// register byte offsets
`define OFS_RESULT_LOW       8'h00
`define OFS_RESULT_HIGH      8'h04
`define OFS_CONV_CONTROL     8'h08
`define OFS_BIAS_ENABLE      8'h0C
`define OFS_RATE_STAGE2      8'h10
`define OFS_STAGE1_STAGE3    8'h14
`define OFS_STAGE3_OFFSET    8'h18
`define OFS_INPUT_REF        8'h1C

// conv_control fields
`define BIT_START            7
`define POS_COUNT_EXP        5
`define POS_RATIO_EXP        2
`define BIT_CONTINUOUS       1
`define BIT_SHIFT_EN         0
// bias_enable fields
`define POS_CONV_BIAS        6
`define POS_AMP_BIAS         4
// input_reference_select fields
`define BIT_BUSY             7
`define BIT_RESTORE          6
`define POS_INPUT_SEL        1
`define BIT_REF_SEL          0

// reset values (also the restore-defaults values, except the input selection, which restore keeps)
`define RST_CONV_CONTROL     8'h28
`define RST_BIAS_ENABLE      8'hF1
`define RST_RATE_STAGE2      8'h00
`define RST_STAGE1_STAGE3    8'h0C
`define RST_STAGE3_OFFSET    8'h00
`define RST_INPUT_REF        8'h00

// timing
`define OSC_FREQ_HZ          4000000
`define FS_BASE_HZ           62500
`define CLK_FREQ_HZ          10000000
`define CLK_PER_FS_BASE      ((`CLK_FREQ_HZ) / (`FS_BASE_HZ))
`define CONV_TAIL_TICKS      11'h004

`endif
